// File: logic/ilc_chan_shift.sv
// ilc_chan_shift: input select, shift, mask and sign extension of one channel
// assumes the control fields are stable register outputs
module ilc_chan_shift (
  // accumulators
  input wire logic [31:0] acc_own,
  input wire logic [31:0] acc_other,
  // control fields
  input wire logic [4:0] shift,
  input wire logic [4:0] lsb,
  input wire logic [4:0] msb,
  input wire logic sgn,
  input wire logic xin,
  input wire logic raw,
  // results
  output logic [31:0] sm,
  output logic [31:0] sx,
  output logic [31:0] pre
);
  logic [31:0] src;

  always_comb begin
    src = xin ? acc_other : acc_own; // see [RULE_13]
    sm = (src >> shift) & ilc_pkg::ilc_mask(lsb, msb); // see [RULE_19] see [RULE_18]
    sx = sm;
    if (sgn && sm[msb]) begin
      sx = sm | ~ilc_pkg::ilc_upto(msb); // see [RULE_15]
    end
    // bypass sits after the input select
    pre = raw ? src : sx; // see [RULE_14] see [RULE_11]
  end
endmodule : ilc_chan_shift

// File: logic/ilc_interp.sv
// ilc_interp: linear interpolation between two offsets by an 8-bit fraction of 256
// assumes purely combinational use inside the datapath
module ilc_interp (
  // operands
  input wire logic [31:0] b0,
  input wire logic [31:0] b1,
  input wire logic [7:0] frac,
  input wire logic sgn,
  // result
  output logic [31:0] res
);
  logic [47:0] e0;
  logic [47:0] e1;
  logic [47:0] w0;
  logic [47:0] w1;
  logic [47:0] sum;

  always_comb begin
    e0 = sgn ? {{16{b0[31]}}, b0} : {16'h0000, b0}; // see [RULE_08]
    e1 = sgn ? {{16{b1[31]}}, b1} : {16'h0000, b1};
    w1 = {40'h0000000000, frac};
    w0 = 48'h000000000100 - w1;
    sum = e0 * w0 + e1 * w1; // see [RULE_05]
    res = sum[39:8];
  end
endmodule : ilc_interp

// File: logic/ilc_lane_ctrl.sv
// ilc_lane_ctrl: interpolator datapath with its register file on an AHB-Lite slave
// assumes one clock, single word transfers, and hready looped from hreadyout
//
// Functional notes
// [RULE_01] Reading the combined nondestructive port returns the full result, alters nothing.
// [RULE_02] Bit 23 flags any accumulator-zero bit set above channel-zero mask top.
// [RULE_03] Bit 24 flags any accumulator-one bit set above channel-one mask top.
// [RULE_04] Bit 25 is the OR of bits 23 and 24.
// [RULE_05] Interpolate mode: channel one blends offset zero and one by 8-bit fraction.
// [RULE_06] Interpolate mode: channel zero yields the low 8 bits of channel one value.
// [RULE_07] Interpolate mode: combined result is offset two plus channel-zero value.
// [RULE_08] Channel-one signed bit selects signed or unsigned interpolation.
// [RULE_09] Interpolate mode bit exists only on the first interpolator.
// [RULE_10] Forced-top field ORs into bus bits 29:28, not the internal value.
// [RULE_11] Raw-add bypasses shift and mask for the channel result only.
// [RULE_12] Swapped feedback loads the opposite channel result on an advancing read.
// [RULE_13] Swapped input feeds the opposite accumulator into shift and mask.
// [RULE_14] Input swap sits ahead of the raw-add bypass.
// [RULE_15] Signed bit sign-extends the masked value from mask top before adding.
// [RULE_16] Signed bit makes channel results read back sign-extended to 32 bits.
// [RULE_17] Software keeps the mask top no lower than the mask bottom.
// [RULE_18] Mask passes only bits from mask bottom to mask top.
// [RULE_19] Accumulator is logically right-shifted by the shift field before masking.
// [RULE_20] Advancing reads return the result and write results back to accumulators.
// [RULE_21] Reading the channel-zero nondestructive port alters nothing.
// [RULE_22] Otherwise results are offset plus value, combined is offset two plus both.
// [RULE_23] Reserved control bits read zero and ignore writes.
// [RULE_24] Control fields clear to zero on reset.
//
// The AHB-Lite slave port was chosen for this implementation.
module ilc_lane_ctrl #(
  parameter bit HAS_MODE = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // ahb-lite data phase
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  typedef struct packed {
    ilc_pkg::ilc_state_e st;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic [7:0] addr;
    logic wr;
    logic [31:0] acc0;
    logic [31:0] acc1;
    logic [31:0] off0;
    logic [31:0] off1;
    logic [31:0] off2;
    logic [21:0] ctl0;
    logic [21:0] ctl1;
  } ilc_regs_s;

  localparam ilc_regs_s REGS_RST = '{
    st: ilc_pkg::ST_IDLE,
    rdy: 1'b1,
    resp: 1'b0,
    rdata: ilc_pkg::WORD_RST,
    addr: 8'h00,
    wr: 1'b0,
    acc0: ilc_pkg::WORD_RST,
    acc1: ilc_pkg::WORD_RST,
    off0: ilc_pkg::WORD_RST,
    off1: ilc_pkg::WORD_RST,
    off2: ilc_pkg::WORD_RST,
    ctl0: ilc_pkg::CTRL_RST,
    ctl1: ilc_pkg::CTRL_RST
  }; // see [RULE_24]

  // the mode bit is writable only where this instance is the first interpolator
  localparam logic [21:0] WMASK0 =
    HAS_MODE ? (ilc_pkg::CTRL_WMASK | ilc_pkg::CTRL_MODE_MASK) : ilc_pkg::CTRL_WMASK; // see [RULE_09]

  ilc_regs_s r_reg;
  ilc_regs_s r_next;

  logic [31:0] sm0;
  logic [31:0] sx0;
  logic [31:0] pre0;
  logic [31:0] sm1;
  logic [31:0] sx1;
  logic [31:0] pre1;
  logic [31:0] blend1;
  logic mode;
  logic ovf0;
  logic ovf1;
  logic [31:0] res0;
  logic [31:0] res1;
  logic [31:0] full;
  logic [31:0] bus0;
  logic [31:0] bus1;
  logic [31:0] ctrl0_view;
  logic [31:0] ctrl1_view;
  logic [31:0] rd_val;
  logic accept;
  logic advance;

  ilc_chan_shift u_chan0 (
    .acc_own(r_reg.acc0),
    .acc_other(r_reg.acc1),
    .shift(r_reg.ctl0[4:0]),
    .lsb(r_reg.ctl0[9:5]),
    .msb(r_reg.ctl0[14:10]),
    .sgn(r_reg.ctl0[ilc_pkg::SIGNED_BIT]),
    .xin(r_reg.ctl0[ilc_pkg::XIN_BIT]),
    .raw(r_reg.ctl0[ilc_pkg::RAW_BIT]),
    .sm(sm0),
    .sx(sx0),
    .pre(pre0)
  );

  ilc_chan_shift u_chan1 (
    .acc_own(r_reg.acc1),
    .acc_other(r_reg.acc0),
    .shift(r_reg.ctl1[4:0]),
    .lsb(r_reg.ctl1[9:5]),
    .msb(r_reg.ctl1[14:10]),
    .sgn(r_reg.ctl1[ilc_pkg::SIGNED_BIT]),
    .xin(r_reg.ctl1[ilc_pkg::XIN_BIT]),
    .raw(r_reg.ctl1[ilc_pkg::RAW_BIT]),
    .sm(sm1),
    .sx(sx1),
    .pre(pre1)
  );

  ilc_interp u_interp (
    .b0(r_reg.off0),
    .b1(r_reg.off1),
    .frac(sm1[7:0]),
    .sgn(r_reg.ctl1[ilc_pkg::SIGNED_BIT]),
    .res(blend1)
  );

  // datapath results and read views
  always_comb begin
    mode = HAS_MODE && r_reg.ctl0[ilc_pkg::MODE_BIT];
    ovf0 = |(r_reg.acc0 & ~ilc_pkg::ilc_upto(r_reg.ctl0[14:10])); // see [RULE_02]
    ovf1 = |(r_reg.acc1 & ~ilc_pkg::ilc_upto(r_reg.ctl1[14:10])); // see [RULE_03]
    if (mode) begin
      res0 = {24'h000000, sm1[7:0]}; // see [RULE_06]
      res1 = blend1; // see [RULE_05]
      full = r_reg.off2 + sx0; // see [RULE_07]
    end else begin
      res0 = r_reg.off0 + pre0; // see [RULE_22] see [RULE_16]
      res1 = r_reg.off1 + pre1;
      full = r_reg.off2 + sx0 + sx1; // see [RULE_22] see [RULE_11]
    end
    bus0 = res0 | {2'b00, r_reg.ctl0[20:19], 28'h0000000}; // see [RULE_10]
    bus1 = res1 | {2'b00, r_reg.ctl1[20:19], 28'h0000000};
    ctrl0_view = {6'h00, ovf0 | ovf1, ovf1, ovf0, 1'b0, r_reg.ctl0}; // see [RULE_04] see [RULE_23]
    ctrl1_view = {10'h000, r_reg.ctl1};
  end

  // read decode, unmapped words read zero
  always_comb begin
    advance = 1'b0;
    case (r_reg.addr)
      ilc_pkg::OFS_ACC0: rd_val = r_reg.acc0;
      ilc_pkg::OFS_ACC1: rd_val = r_reg.acc1;
      ilc_pkg::OFS_OFF0: rd_val = r_reg.off0;
      ilc_pkg::OFS_OFF1: rd_val = r_reg.off1;
      ilc_pkg::OFS_OFF2: rd_val = r_reg.off2;
      ilc_pkg::OFS_ADV_C0: begin
        rd_val = bus0;
        advance = 1'b1;
      end
      ilc_pkg::OFS_ADV_C1: begin
        rd_val = bus1;
        advance = 1'b1;
      end
      ilc_pkg::OFS_ADV_ALL: begin
        rd_val = full;
        advance = 1'b1;
      end
      ilc_pkg::OFS_NDR_C0: rd_val = bus0; // see [RULE_21]
      ilc_pkg::OFS_NDR_C1: rd_val = bus1;
      ilc_pkg::OFS_NDR_ALL: rd_val = full; // see [RULE_01]
      ilc_pkg::OFS_CTRL0: rd_val = ctrl0_view;
      ilc_pkg::OFS_CTRL1: rd_val = ctrl1_view;
      default: rd_val = ilc_pkg::WORD_RST;
    endcase
  end

  // bus sequencing: one wait state, then the registered answer
  always_comb begin
    r_next = r_reg;
    accept = hsel && hready && htrans[1] && r_reg.rdy;
    case (r_reg.st)
      ilc_pkg::ST_IDLE: begin
        if (accept) begin
          r_next.st = ilc_pkg::ST_ACCESS;
          r_next.rdy = 1'b0;
          r_next.addr = haddr[7:0];
          r_next.wr = hwrite;
        end
      end
      ilc_pkg::ST_ACCESS: begin
        r_next.st = ilc_pkg::ST_IDLE;
        r_next.rdy = 1'b1;
        if (r_reg.wr) begin
          case (r_reg.addr)
            ilc_pkg::OFS_ACC0: r_next.acc0 = hwdata;
            ilc_pkg::OFS_ACC1: r_next.acc1 = hwdata;
            ilc_pkg::OFS_OFF0: r_next.off0 = hwdata;
            ilc_pkg::OFS_OFF1: r_next.off1 = hwdata;
            ilc_pkg::OFS_OFF2: r_next.off2 = hwdata;
            ilc_pkg::OFS_CTRL0: r_next.ctl0 = hwdata[21:0] & WMASK0; // see [RULE_23]
            ilc_pkg::OFS_CTRL1: r_next.ctl1 = hwdata[21:0] & ilc_pkg::CTRL_WMASK;
            default: r_next.rdata = r_reg.rdata;
          endcase
        end else begin
          r_next.rdata = rd_val;
          if (advance) begin
            r_next.acc0 = r_reg.ctl0[ilc_pkg::XRES_BIT] ? res1 : res0; // see [RULE_20] see [RULE_12]
            r_next.acc1 = r_reg.ctl1[ilc_pkg::XRES_BIT] ? res0 : res1; // see [RULE_12]
          end
        end
      end
      default: r_next = REGS_RST;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = r_reg.rdy;
  assign hrdata = r_reg.rdata;
  assign hresp = r_reg.resp;

  // checks
  logic rd_now;
  assign rd_now = (r_reg.st == ilc_pkg::ST_ACCESS) && !r_reg.wr;

  property p_ndr_all;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_NDR_ALL) |=>
      ($stable(r_reg.acc0) && $stable(r_reg.acc1) && r_reg.rdata == $past(full));
  endproperty
  a_ndr_all: assert property (p_ndr_all) else $error("combined read changed state"); // see [RULE_01]

  property p_ndr_c0;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_NDR_C0) |=> ($stable(r_reg.acc0) && $stable(r_reg.acc1));
  endproperty
  a_ndr_c0: assert property (p_ndr_c0) else $error("channel read changed state"); // see [RULE_21]

  property p_ovf0;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_CTRL0) |=>
      r_reg.rdata[23] == (($past(r_reg.acc0) >> ({1'b0, $past(r_reg.ctl0[14:10])} + 6'd1)) != 32'h0);
  endproperty
  a_ovf0: assert property (p_ovf0) else $error("overflow zero wrong"); // see [RULE_02]

  property p_ovf1;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_CTRL0) |=>
      r_reg.rdata[24] == (($past(r_reg.acc1) >> ({1'b0, $past(r_reg.ctl1[14:10])} + 6'd1)) != 32'h0);
  endproperty
  a_ovf1: assert property (p_ovf1) else $error("overflow one wrong"); // see [RULE_03]

  property p_ovfa;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_CTRL0) |=> r_reg.rdata[25] == (r_reg.rdata[23] | r_reg.rdata[24]);
  endproperty
  a_ovfa: assert property (p_ovfa) else $error("summary overflow wrong"); // see [RULE_04]

  property p_rsvd;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_CTRL0) |=> (r_reg.rdata[31:26] == 6'h00 && !r_reg.rdata[22]);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // see [RULE_23]

  property p_mode_c0;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_NDR_C0 && mode && r_reg.ctl0[20:19] == 2'b00) |=>
      r_reg.rdata == {24'h000000, $past(sm1[7:0])};
  endproperty
  a_mode_c0: assert property (p_mode_c0) else $error("mode channel zero wrong"); // see [RULE_06]

  property p_mode_all;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_NDR_ALL && mode) |=> r_reg.rdata == $past(r_reg.off2) + $past(sx0);
  endproperty
  a_mode_all: assert property (p_mode_all) else $error("mode combined wrong"); // see [RULE_07]

  property p_force;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_NDR_C0) |=>
      ((r_reg.rdata[29:28] & $past(r_reg.ctl0[20:19])) == $past(r_reg.ctl0[20:19]));
  endproperty
  a_force: assert property (p_force) else $error("forced top bits missing"); // see [RULE_10]

  property p_adv;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_ADV_C0 && !r_reg.ctl0[17] && !r_reg.ctl1[17]) |=>
      (r_reg.acc0 == $past(res0) && r_reg.acc1 == $past(res1));
  endproperty
  a_adv: assert property (p_adv) else $error("advance writeback wrong"); // see [RULE_20]

  // swapped feedback on channel zero only: both accumulators take the channel-one result
  property p_xres;
    @(posedge hclk) disable iff (!hresetn)
    (rd_now && r_reg.addr == ilc_pkg::OFS_ADV_C1 &&
      r_reg.ctl0[ilc_pkg::XRES_BIT] && !r_reg.ctl1[ilc_pkg::XRES_BIT]) |=>
      (r_reg.acc0 == $past(res1) && r_reg.acc1 == $past(res1));
  endproperty
  a_xres: assert property (p_xres) else $error("swapped writeback wrong"); // see [RULE_12]

  // bits outside the window must be zero while the bounds are in order
  property p_mask0;
    @(posedge hclk) disable iff (!hresetn)
    (r_reg.ctl0[14:10] >= r_reg.ctl0[9:5]) |->
      (((sm0 >> r_reg.ctl0[14:10]) >> 1) == 32'h00000000) &&
      ((sm0 & ((32'h00000001 << r_reg.ctl0[9:5]) - 32'h00000001)) == 32'h00000000);
  endproperty
  a_mask0: assert property (p_mask0) else $error("mask passes outside bits"); // see [RULE_18]

  // the top passed bit is the accumulator bit one shift above it
  property p_shift0;
    @(posedge hclk) disable iff (!hresetn)
    (!r_reg.ctl0[ilc_pkg::XIN_BIT] && r_reg.ctl0[14:10] >= r_reg.ctl0[9:5]) |->
      ((sm0 >> r_reg.ctl0[14:10]) & 32'h00000001) ==
      (((r_reg.acc0 >> r_reg.ctl0[4:0]) >> r_reg.ctl0[14:10]) & 32'h00000001);
  endproperty
  a_shift0: assert property (p_shift0) else $error("shift before mask wrong"); // see [RULE_19]

  property p_wait;
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && hreadyout) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state timing wrong");

endmodule : ilc_lane_ctrl

// File: logic/ilc_pkg.sv
// ilc_pkg: offsets, field positions, reset values and shared helpers of the interpolator block
// assumes a 32-bit word bus where each register occupies one aligned word
package ilc_pkg;

  // byte addresses of the register words
  localparam logic [7:0] OFS_ACC0 = 8'h80;
  localparam logic [7:0] OFS_ACC1 = 8'h84;
  localparam logic [7:0] OFS_OFF0 = 8'h88;
  localparam logic [7:0] OFS_OFF1 = 8'h8C;
  localparam logic [7:0] OFS_OFF2 = 8'h90;
  localparam logic [7:0] OFS_ADV_C0 = 8'h94;
  localparam logic [7:0] OFS_ADV_C1 = 8'h98;
  localparam logic [7:0] OFS_ADV_ALL = 8'h9C;
  localparam logic [7:0] OFS_NDR_C0 = 8'hA0;
  localparam logic [7:0] OFS_NDR_C1 = 8'hA4;
  localparam logic [7:0] OFS_NDR_ALL = 8'hA8;
  localparam logic [7:0] OFS_CTRL0 = 8'hAC;
  localparam logic [7:0] OFS_CTRL1 = 8'hB0;

  // control field positions
  localparam int SHIFT_LO = 0;
  localparam int LSB_LO = 5;
  localparam int MSB_LO = 10;
  localparam int SIGNED_BIT = 15;
  localparam int XIN_BIT = 16;
  localparam int XRES_BIT = 17;
  localparam int RAW_BIT = 18;
  localparam int FORCE_LO = 19;
  localparam int MODE_BIT = 21;
  localparam int OVF0_BIT = 23;
  localparam int OVF1_BIT = 24;
  localparam int OVFA_BIT = 25;
  localparam int FORCE_DST_LO = 28;

  localparam int CTRL_W = 22;
  localparam logic [21:0] CTRL_RST = 22'h000000;
  localparam logic [21:0] CTRL_WMASK = 22'h1FFFFF;
  localparam logic [21:0] CTRL_MODE_MASK = 22'h200000;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam int FRAC_W = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } ilc_state_e;

  // ones from bit 0 up to and including msb
  function automatic logic [31:0] ilc_upto(input logic [4:0] msb);
    ilc_upto = 32'hFFFFFFFF >> (5'd31 - msb);
  endfunction : ilc_upto

  // ones from lsb up to msb inclusive
  function automatic logic [31:0] ilc_mask(input logic [4:0] lsb, input logic [4:0] msb);
    ilc_mask = (32'hFFFFFFFF << lsb) & ilc_upto(msb);
  endfunction : ilc_mask

endpackage : ilc_pkg

// File: test/ilc_ahb_master.sv
// ilc_ahb_master: processor-side model issuing single word transfers on the register bus
// assumes hready is the slave's hreadyout and a single clock domain
module ilc_ahb_master (
  // clock
  input wire logic hclk,
  // request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic timed_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    timed_out = 1'b0;
  end

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) timed_out = 1'b1;
  endtask : wait_ready

  // address phase held until accepted, then data phase held until done
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    hsel <= 1'b0;
  endtask : xfer
endmodule : ilc_ahb_master

// File: test/test_interpolator_lane_control.sv
// test_interpolator_lane_control: register-level checks of the interpolator datapath
// assumes the bus model in ilc_ahb_master and the register map of ilc_pkg
module test_interpolator_lane_control;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] SGN = 32'h00008000;
  localparam logic [31:0] XIN = 32'h00010000;
  localparam logic [31:0] XRES = 32'h00020000;
  localparam logic [31:0] RAW = 32'h00040000;
  localparam logic [31:0] FRC = 32'h00180000;
  localparam logic [31:0] MODE = 32'h00200000;

  logic hclk, hresetn, hsel, hwrite, hready, hresp, tmo;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int mismatches = 0;
  int num_checks = 0;

  ilc_lane_ctrl #(.HAS_MODE(1'b1)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp));

  ilc_ahb_master bus (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .timed_out(tmo));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus.xfer(a, 1'b1, d, x);
    if (tmo) begin
      mismatches++;
      results();
    end
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus.xfer(a, 1'b0, 32'h00000000, x);
    if (tmo) begin
      mismatches++;
      results();
    end
    chk(x, e);
    chk({31'h00000000, hresp}, 32'h00000000);
  endtask : rc

  // control word from shift, mask bounds and flag bits; every caller keeps the top bound at or above the bottom
  function automatic logic [31:0] ctl(input logic [4:0] sh, lo, hi, input logic [31:0] f);
    ctl = {17'h00000, hi, lo, sh} | f;
  endfunction : ctl

  initial begin
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rc(ilc_pkg::OFS_CTRL0, 32'h00000000);
    rc(ilc_pkg::OFS_NDR_ALL, 32'h00000000);
    wr(ilc_pkg::OFS_CTRL0, 32'hFFFFFFFF);
    rc(ilc_pkg::OFS_CTRL0, 32'h003FFFFF);
    wr(8'hC0, 32'h00000055);
    rc(8'hC0, 32'h00000000);
    // shift by 4, pass bits 2..9, plus overflow flags
    wr(ilc_pkg::OFS_ACC0, 32'h12345678);
    wr(ilc_pkg::OFS_ACC1, 32'h00000003);
    wr(ilc_pkg::OFS_OFF0, 32'h00000100);
    wr(ilc_pkg::OFS_OFF2, 32'h00001000);
    wr(ilc_pkg::OFS_CTRL0, ctl(5'd4, 5'd2, 5'd9, 32'h00000000));
    rc(ilc_pkg::OFS_NDR_C0, 32'h00000264);
    rc(ilc_pkg::OFS_NDR_ALL, 32'h00001165);
    rc(ilc_pkg::OFS_ACC0, 32'h12345678);
    rc(ilc_pkg::OFS_CTRL0, 32'h03802444);
    wr(ilc_pkg::OFS_ACC1, 32'h00000001);
    rc(ilc_pkg::OFS_CTRL0, 32'h02802444);
    // advancing read writes results back
    rc(ilc_pkg::OFS_ADV_C0, 32'h00000264);
    rc(ilc_pkg::OFS_ACC0, 32'h00000264);
    rc(ilc_pkg::OFS_ACC1, 32'h00000001);
    wr(ilc_pkg::OFS_ACC0, 32'h12345678);
    wr(ilc_pkg::OFS_ACC1, 32'h00000005);
    wr(ilc_pkg::OFS_OFF1, 32'h00000030);
    wr(ilc_pkg::OFS_CTRL0, ctl(5'd4, 5'd2, 5'd9, XRES));
    rc(ilc_pkg::OFS_ADV_C1, 32'h00000031);
    rc(ilc_pkg::OFS_ACC0, 32'h00000031);
    rc(ilc_pkg::OFS_ACC1, 32'h00000031);
    // sign extension from mask top
    wr(ilc_pkg::OFS_ACC0, 32'h00000080);
    wr(ilc_pkg::OFS_OFF0, 32'h00000010);
    wr(ilc_pkg::OFS_CTRL0, ctl(5'd0, 5'd0, 5'd7, SGN));
    rc(ilc_pkg::OFS_NDR_C0, 32'hFFFFFF90);
    rc(ilc_pkg::OFS_NDR_ALL, 32'h00000F81);
    // raw add with swapped input
    wr(ilc_pkg::OFS_ACC1, 32'h00001230);
    wr(ilc_pkg::OFS_CTRL0, ctl(5'd4, 5'd2, 5'd9, RAW | XIN));
    rc(ilc_pkg::OFS_NDR_C0, 32'h00001240);
    rc(ilc_pkg::OFS_NDR_ALL, 32'h00001120);
    // forced top bits on the bus only
    wr(ilc_pkg::OFS_ACC0, 32'h00000011);
    wr(ilc_pkg::OFS_CTRL0, ctl(5'd0, 5'd0, 5'd31, FRC));
    rc(ilc_pkg::OFS_ADV_C0, 32'h30000021);
    rc(ilc_pkg::OFS_ACC0, 32'h00000021);
    // interpolate mode
    wr(ilc_pkg::OFS_CTRL1, ctl(5'd0, 5'd0, 5'd7, 32'h00000000));
    wr(ilc_pkg::OFS_ACC1, 32'h00000040);
    wr(ilc_pkg::OFS_OFF0, 32'h00000100);
    wr(ilc_pkg::OFS_OFF1, 32'h00000200);
    wr(ilc_pkg::OFS_CTRL0, ctl(5'd0, 5'd0, 5'd31, MODE));
    rc(ilc_pkg::OFS_NDR_C1, 32'h00000140);
    rc(ilc_pkg::OFS_NDR_C0, 32'h00000040);
    rc(ilc_pkg::OFS_NDR_ALL, 32'h00001021);
    wr(ilc_pkg::OFS_OFF0, 32'h00000000);
    wr(ilc_pkg::OFS_OFF1, 32'hFFFFFF00);
    wr(ilc_pkg::OFS_ACC1, 32'h00000080);
    // the mode bit has no place in the channel-one register
    wr(ilc_pkg::OFS_CTRL1, ctl(5'd0, 5'd0, 5'd7, SGN | MODE));
    rc(ilc_pkg::OFS_NDR_C1, 32'hFFFFFF80);
    rc(ilc_pkg::OFS_CTRL1, 32'h00009C00);
    // advancing combined read in interpolate mode
    rc(ilc_pkg::OFS_ADV_ALL, 32'h00001021);
    rc(ilc_pkg::OFS_ACC0, 32'h00000080);
    rc(ilc_pkg::OFS_ACC1, 32'hFFFFFF80);
    // reset in mid-run clears all state again
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(ilc_pkg::OFS_CTRL0, 32'h00000000);
    rc(ilc_pkg::OFS_CTRL1, 32'h00000000);
    rc(ilc_pkg::OFS_ACC1, 32'h00000000);
    rc(ilc_pkg::OFS_OFF1, 32'h00000000);
    results();
  end
endmodule : test_interpolator_lane_control
